// [core/atb_pkg.sv]
package atb_pkg;
	// store geometry
	localparam int          ENTRIES  = 32;
	localparam int          IDX_W    = 5;
	localparam int          TAG_W    = 8;
	localparam int          VPN2_W   = 27;
	localparam int          PFN_W    = 20;
	localparam int          PA_W     = 32;
	localparam int          VA_W     = 64;
	// page sizes: offset width is 12 + 2 * size code, codes 0..6 give 4K..16M
	localparam logic [4:0]  PAGE_MIN_SHIFT = 5'hC;
	localparam logic [2:0]  SIZE_MAX       = 3'h6;
	localparam logic [11:0] PFN_PAD        = 12'h000;
	// direct kernel windows, selected by address bits 31:29
	localparam logic [2:0]  WIN0_SEL  = 3'h4;
	localparam logic [2:0]  WIN1_SEL  = 3'h5;
	localparam logic [31:0] WIN0_BASE = 32'h8000_0000;
	localparam logic [31:0] WIN1_BASE = 32'hA000_0000;
	localparam logic [31:0] SIGN_HIGH = 32'hFFFF_FFFF;
	// cache attributes reported for the windows
	localparam logic [2:0]  WIN0_CACHE = 3'h3;
	localparam logic [2:0]  WIN1_CACHE = 3'h2;
	// user region: bit 31 clear in 32-bit mode, bits 63:40 clear in 64-bit mode
	localparam logic [23:0] USER64_HIGH = 24'h000000;
	localparam logic [7:0]  VPN2_PAD32  = 8'h00;
	localparam logic [IDX_W-1:0] RANDOM_RESET = 5'h1F;

	typedef struct packed {
		logic [PFN_W-1:0] pfn;
		logic [2:0]       cache;
		logic             writable;
		logic             valid;
	} atb_page_t;

	typedef struct packed {
		logic [VPN2_W-1:0] vpn2;
		logic [2:0]        size;
		logic              all_spaces;
		logic [TAG_W-1:0]  space_tag;
		atb_page_t         even;
		atb_page_t         odd;
	} atb_entry_t;
endpackage

// [core/atb_store.sv]
`timescale 1ns/1ns
module atb_store #(
	parameter int N     = 32,
	parameter int IDX_W = 5
) (
	// clock and reset
	input  wire logic                          clk_in,
	input  wire logic                          rst_in,
	// refill write
	input  wire logic                          wr_en_in,
	input  wire logic [IDX_W-1:0]              wr_idx_in,
	input  wire atb_pkg::atb_entry_t           wr_entry_in,
	// every entry, for the parallel compare
	output atb_pkg::atb_entry_t [N-1:0]        entries_out
);
	atb_pkg::atb_entry_t wr_clamped;

	// an illegal size code is held at the largest page so compare stays sane
	always_comb
	begin
		wr_clamped = wr_entry_in;
		if (wr_entry_in.size > atb_pkg::SIZE_MAX)
			wr_clamped.size = atb_pkg::SIZE_MAX;
	end

	// entries are registers, all readable in parallel for the compare
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			entries_out <= '0;
		else if (wr_en_in)
			entries_out[wr_idx_in] <= wr_clamped;
	end
endmodule // atb_store

// [core/atb_core.sv]
`timescale 1ns/1ns
// Contract
// - 32 fully associative entries, each mapping an even/odd page pair.
// - all entries compared at once against address plus current space tag.
// - page sizes 4K, 16K, 64K, 256K, 1M, 4M, 16M.
// - hit: matched physical page number joined with in-page offset.
// - offset bits pass straight to the low physical address bits.
// - no match raises a miss indication.
// - entries written by explicit index or by a pseudo-random pointer.
// - single hit reports address with cache, writable and valid attributes.
// - clear valid gives invalid; store to non-writable page gives modify.
// - direct windows: physical address is virtual minus window base.
// - addresses 32 bits wide in 32-bit mode, 64 in 64-bit mode.
// - user region limited to 2 GB (32-bit) or 1 TB (64-bit).
// - space tag is 8 bits from the translation key register.
// - physical addresses are 32 bits wide.
// - hit needs equal page number and all-spaces bit or equal tag.
// - 32-bit mode, 4K pages: 12-bit offset, 20-bit page number.
// - 64-bit mode, 4K pages: 12-bit offset, 28-bit page number.
module atb_core #(
	parameter int ENTRIES = atb_pkg::ENTRIES
) (
	// clock and reset
	input  wire logic                          CLOCK_IN,
	input  wire logic                          RESET_IN,
	// processor state
	input  wire logic                          MODE64_IN,
	input  wire logic                          KERNEL_MODE_IN,
	input  wire logic                          USER_MODE_IN,
	input  wire logic [atb_pkg::TAG_W-1:0]     KEY_TAG_IN,
	// translation request
	input  wire logic                          REQ_VALID_IN,
	input  wire logic                          REQ_FETCH_IN,
	input  wire logic                          REQ_STORE_IN,
	input  wire logic [atb_pkg::VA_W-1:0]      REQ_VADDR_IN,
	// entry refill
	input  wire logic                          WR_INDEX_EN_IN,
	input  wire logic                          WR_RANDOM_EN_IN,
	input  wire logic [atb_pkg::IDX_W-1:0]     WR_INDEX_IN,
	input  wire atb_pkg::atb_entry_t           WR_ENTRY_IN,
	// translation answer
	output logic                               RSP_VALID_OUT,
	output logic [atb_pkg::PA_W-1:0]           RSP_PADDR_OUT,
	output logic [2:0]                         RSP_CACHE_OUT,
	output logic                               RSP_WRITABLE_OUT,
	output logic                               RSP_PAGE_VALID_OUT,
	output logic                               RSP_HIT_OUT,
	// fault indications
	output logic                               I_MISS_OUT,
	output logic                               I_INVALID_OUT,
	output logic                               D_MISS_OUT,
	output logic                               D_INVALID_OUT,
	output logic                               D_MODIFY_OUT,
	output logic                               ADDR_ERR_OUT,
	// refill pointer
	output logic [atb_pkg::IDX_W-1:0]          RANDOM_OUT
);
	atb_pkg::atb_entry_t [ENTRIES-1:0] entries;
	atb_pkg::atb_entry_t               sel_entry;
	atb_pkg::atb_page_t                sel_page;
	logic [atb_pkg::IDX_W-1:0]         random_q;
	logic [atb_pkg::IDX_W-1:0]         wr_idx;
	logic [atb_pkg::VPN2_W-1:0]        va_vpn2;
	logic [ENTRIES-1:0]                hit_vec;
	logic                              hit_any;
	logic [4:0]                        offset_w;
	logic [31:0]                       off_mask;
	logic [31:0]                       mapped_pa;
	logic                              win0;
	logic                              win1;
	logic                              addr_err;
	logic                              mapped;

	// random pointer counts down every clock and wraps to the top
	always_ff @(posedge CLOCK_IN or posedge RESET_IN)
	begin
		if (RESET_IN)
			random_q <= atb_pkg::RANDOM_RESET;
		else
			random_q <= random_q - 5'h01;
	end

	// index write wins when software asks for both at once
	assign wr_idx = WR_INDEX_EN_IN ? WR_INDEX_IN : random_q;

	atb_store #(
		.N     (ENTRIES),
		.IDX_W (atb_pkg::IDX_W)
	) u_store (
		.clk_in      (CLOCK_IN),
		.rst_in      (RESET_IN),
		.wr_en_in    (WR_INDEX_EN_IN | WR_RANDOM_EN_IN),
		.wr_idx_in   (wr_idx),
		.wr_entry_in (WR_ENTRY_IN),
		.entries_out (entries)
	);

	// page number field; upper bits are ignored in 32-bit mode
	assign va_vpn2 = MODE64_IN ? REQ_VADDR_IN[39:13]
	                           : {atb_pkg::VPN2_PAD32, REQ_VADDR_IN[31:13]};

	// parallel compare; a multiple match ORs entries, which software forbids
	always_comb
	begin
		logic [atb_pkg::VPN2_W-1:0] m;
		m = '0;
		hit_vec = '0;
		sel_entry = '0;
		for (int i = 0; i < ENTRIES; i++)
		begin
			m = (27'h1 << {entries[i].size, 1'b0}) - 27'h1;
			hit_vec[i] = ((entries[i].vpn2 & ~m) == (va_vpn2 & ~m))
				&& (entries[i].all_spaces
				|| entries[i].space_tag == KEY_TAG_IN);
			if (hit_vec[i])
				sel_entry = sel_entry | entries[i];
		end
	end

	assign hit_any = |hit_vec;

	// offset width and even/odd choice follow the matched page size
	assign offset_w = atb_pkg::PAGE_MIN_SHIFT + {1'b0, sel_entry.size, 1'b0};
	assign off_mask = (32'h1 << offset_w) - 32'h1;
	assign sel_page = REQ_VADDR_IN[offset_w] ? sel_entry.odd : sel_entry.even;

	// frame number joined with the untranslated offset
	assign mapped_pa = ({sel_page.pfn, atb_pkg::PFN_PAD} & ~off_mask)
		| (REQ_VADDR_IN[31:0] & off_mask);

	// direct windows need kernel mode and a sign-extended address in 64-bit mode
	assign win0 = KERNEL_MODE_IN && REQ_VADDR_IN[31:29] == atb_pkg::WIN0_SEL
		&& (!MODE64_IN || REQ_VADDR_IN[63:32] == atb_pkg::SIGN_HIGH);
	assign win1 = KERNEL_MODE_IN && REQ_VADDR_IN[31:29] == atb_pkg::WIN1_SEL
		&& (!MODE64_IN || REQ_VADDR_IN[63:32] == atb_pkg::SIGN_HIGH);

	// user accesses outside the user region never reach the compare
	assign addr_err = USER_MODE_IN && (MODE64_IN
		? REQ_VADDR_IN[63:40] != atb_pkg::USER64_HIGH
		: REQ_VADDR_IN[31]);
	assign mapped = REQ_VALID_IN && !addr_err && !win0 && !win1;

	// answer address and attributes, all stamped in one cycle
	always_ff @(posedge CLOCK_IN or posedge RESET_IN)
	begin
		if (RESET_IN)
		begin
			RSP_VALID_OUT      <= 1'b0;
			RSP_PADDR_OUT      <= '0;
			RSP_CACHE_OUT      <= '0;
			RSP_WRITABLE_OUT   <= 1'b0;
			RSP_PAGE_VALID_OUT <= 1'b0;
			RSP_HIT_OUT        <= 1'b0;
		end
		else
		begin
			RSP_VALID_OUT <= REQ_VALID_IN;
			if (win0 || win1)
			begin
				RSP_PADDR_OUT      <= REQ_VADDR_IN[31:0]
					- (win0 ? atb_pkg::WIN0_BASE : atb_pkg::WIN1_BASE);
				RSP_CACHE_OUT      <= win0 ? atb_pkg::WIN0_CACHE : atb_pkg::WIN1_CACHE;
				RSP_WRITABLE_OUT   <= 1'b1;
				RSP_PAGE_VALID_OUT <= 1'b1;
				RSP_HIT_OUT        <= 1'b0;
			end
			else
			begin
				RSP_PADDR_OUT      <= mapped_pa;
				RSP_CACHE_OUT      <= sel_page.cache;
				RSP_WRITABLE_OUT   <= sel_page.writable;
				RSP_PAGE_VALID_OUT <= sel_page.valid;
				RSP_HIT_OUT        <= mapped && hit_any;
			end
		end
	end

	// fault flags, all but the address error split by fetch or data so the stage logic can rank them
	always_ff @(posedge CLOCK_IN or posedge RESET_IN)
	begin
		if (RESET_IN)
		begin
			I_MISS_OUT    <= 1'b0;
			I_INVALID_OUT <= 1'b0;
			D_MISS_OUT    <= 1'b0;
			D_INVALID_OUT <= 1'b0;
			D_MODIFY_OUT  <= 1'b0;
			ADDR_ERR_OUT  <= 1'b0;
		end
		else
		begin
			I_MISS_OUT    <= mapped && REQ_FETCH_IN && !hit_any;
			D_MISS_OUT    <= mapped && !REQ_FETCH_IN && !hit_any;
			I_INVALID_OUT <= mapped && REQ_FETCH_IN && hit_any && !sel_page.valid;
			D_INVALID_OUT <= mapped && !REQ_FETCH_IN && hit_any && !sel_page.valid;
			D_MODIFY_OUT  <= mapped && !REQ_FETCH_IN && REQ_STORE_IN && hit_any
				&& sel_page.valid && !sel_page.writable;
			ADDR_ERR_OUT  <= REQ_VALID_IN && addr_err;
		end
	end

	assign RANDOM_OUT = random_q;

	offset_pass_a: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		REQ_VALID_IN |=> RSP_PADDR_OUT[11:0] == $past(REQ_VADDR_IN[11:0]))
		else $error("offset bits changed by translation");

	miss_raise_a: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		mapped && !hit_any |=> (I_MISS_OUT || D_MISS_OUT) && !RSP_HIT_OUT)
		else $error("no match but no miss flag");

	invalid_raise_a: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		RSP_HIT_OUT && !RSP_PAGE_VALID_OUT |-> I_INVALID_OUT || D_INVALID_OUT)
		else $error("hit on invalid page without invalid flag");

	modify_raise_a: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		D_MODIFY_OUT |-> RSP_PAGE_VALID_OUT && !RSP_WRITABLE_OUT
			&& $past(REQ_STORE_IN) && !D_INVALID_OUT)
		else $error("modify flag without store to read-only page");

	direct_window_a: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		REQ_VALID_IN && win1 |=> RSP_PADDR_OUT == $past(REQ_VADDR_IN[31:0]) - atb_pkg::WIN1_BASE
			&& !RSP_HIT_OUT && !D_MISS_OUT)
		else $error("direct window address wrong");

	tag_match_a: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		hit_any && $onehot(hit_vec) |-> sel_entry.all_spaces || sel_entry.space_tag == KEY_TAG_IN)
		else $error("hit with foreign space tag");

	user_limit_a: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		REQ_VALID_IN && USER_MODE_IN && !MODE64_IN && REQ_VADDR_IN[31]
			|=> ADDR_ERR_OUT && !RSP_HIT_OUT && !D_MISS_OUT && !I_MISS_OUT)
		else $error("user access above 2 GB not refused");

	random_step_a: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		RANDOM_OUT == 5'h00 |=> RANDOM_OUT == 5'h1F ##1 RANDOM_OUT == 5'h1E)
		else $error("random pointer does not wrap");

	fetch_split_a: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		(I_MISS_OUT || I_INVALID_OUT) |-> !D_MISS_OUT && !D_INVALID_OUT && !D_MODIFY_OUT
			&& $past(REQ_FETCH_IN))
		else $error("fetch fault mixed with data fault");

	hit_seen_c: cover property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		RSP_VALID_OUT && RSP_HIT_OUT && RSP_PAGE_VALID_OUT);
	miss_seen_c: cover property (@(posedge CLOCK_IN) disable iff (RESET_IN) D_MISS_OUT);
	modify_seen_c: cover property (@(posedge CLOCK_IN) disable iff (RESET_IN) D_MODIFY_OUT);
	window_seen_c: cover property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		REQ_VALID_IN && win0);
endmodule // atb_core

// [test/atb_pipe_model.sv]
`timescale 1ns/1ns
module atb_pipe_model (
	// clock
	input  wire logic                clk_in,
	// translation request
	output logic                     req_valid_out,
	output logic                     req_fetch_out,
	output logic                     req_store_out,
	output logic [63:0]              req_vaddr_out,
	// entry refill
	output logic                     wr_index_en_out,
	output logic                     wr_random_en_out,
	output logic [4:0]               wr_index_out,
	output atb_pkg::atb_entry_t      wr_entry_out
);
	// idle values at time zero; address and entry lines carry junk when unused
	initial
	begin
		req_valid_out = 1'b0;
		req_fetch_out = 1'b0;
		req_store_out = 1'b0;
		req_vaddr_out = 64'h5A5A_5A5A_5A5A_5A5A;
		wr_index_en_out = 1'b0;
		wr_random_en_out = 1'b0;
		wr_index_out = 5'h0A;
		wr_entry_out = '1;
	end

	// one request strobe, answer lands at the edge that ends this task
	task automatic request(input logic f, input logic s, input logic [63:0] va);
		@(posedge clk_in);
		#1;
		req_valid_out = 1'b1;
		req_fetch_out = f;
		req_store_out = s;
		req_vaddr_out = va;
		@(posedge clk_in);
		#1;
		req_valid_out = 1'b0;
		req_vaddr_out = ~va;
	endtask

	// one refill write; the caller never loads two entries matching one address
	task automatic refill(input logic rnd, input logic [4:0] idx, input atb_pkg::atb_entry_t e);
		@(posedge clk_in);
		#1;
		wr_index_en_out = ~rnd;
		wr_random_en_out = rnd;
		wr_index_out = idx;
		wr_entry_out = e;
		@(posedge clk_in);
		#1;
		wr_index_en_out = 1'b0;
		wr_random_en_out = 1'b0;
		wr_entry_out = ~e;
	endtask
endmodule // atb_pipe_model

// [test/tb.sv]
`timescale 1ns/1ns
module tb;
	logic clk, rst, m64, kern, usr, rv, rf, rs, wi, wr;
	logic [7:0] key;
	logic [63:0] va;
	logic [4:0] widx, rnd, r;
	atb_pkg::atb_entry_t went;
	logic [31:0] pa, paddr;
	logic [2:0] cache;
	logic wrt, pv, hit, rspv, im, ii, dm, di, dmod, ae;
	int fail_count = 0;
	int num_checks = 0;

	atb_pipe_model i_atb_pipe_model (.clk_in(clk), .req_valid_out(rv), .req_fetch_out(rf),
		.req_store_out(rs), .req_vaddr_out(va), .wr_index_en_out(wi), .wr_random_en_out(wr),
		.wr_index_out(widx), .wr_entry_out(went));
	atb_core i_atb_core (.CLOCK_IN(clk), .RESET_IN(rst), .MODE64_IN(m64), .KERNEL_MODE_IN(kern),
		.USER_MODE_IN(usr), .KEY_TAG_IN(key), .REQ_VALID_IN(rv), .REQ_FETCH_IN(rf),
		.REQ_STORE_IN(rs), .REQ_VADDR_IN(va), .WR_INDEX_EN_IN(wi), .WR_RANDOM_EN_IN(wr),
		.WR_INDEX_IN(widx), .WR_ENTRY_IN(went), .RSP_VALID_OUT(rspv), .RSP_PADDR_OUT(paddr),
		.RSP_CACHE_OUT(cache), .RSP_WRITABLE_OUT(wrt), .RSP_PAGE_VALID_OUT(pv),
		.RSP_HIT_OUT(hit), .I_MISS_OUT(im), .I_INVALID_OUT(ii), .D_MISS_OUT(dm),
		.D_INVALID_OUT(di), .D_MODIFY_OUT(dmod), .ADDR_ERR_OUT(ae), .RANDOM_OUT(rnd));

	// 250 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		num_checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic report_and_stop;
		$display("checks %0d failures %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	function automatic atb_pkg::atb_page_t pg(logic [19:0] p, logic [2:0] c, logic w, logic v);
		return '{pfn: p, cache: c, writable: w, valid: v};
	endfunction

	function automatic atb_pkg::atb_entry_t ent(logic [26:0] v2, logic [2:0] sz, logic g,
		atb_pkg::atb_page_t ev, atb_pkg::atb_page_t od);
		return '{vpn2: v2, size: sz, all_spaces: g, space_tag: 8'h05, even: ev, odd: od};
	endfunction

	// one request; t is {cache, writable, page valid, hit}, e the six fault flags
	// miss, invalid and address-error cases compare only strobe, hit and flags
	task automatic xq(input logic f, input logic s, input logic [63:0] a, input logic [31:0] p,
		input logic [5:0] t, input logic [5:0] e, input logic full);
		logic [44:0] g, x, m;
		i_atb_pipe_model.request(f, s, a);
		g = {rspv, paddr, cache, wrt, pv, hit, im, ii, dm, di, dmod, ae};
		x = {1'b1, p, t, e};
		m = full ? '1 : {1'b1, 37'h0, 7'h7F};
		chk(64'(g & m), 64'(x & m));
	endtask

	initial
	begin
		{rst, m64, kern, usr} = 4'h8;
		key = 8'h05;
		repeat (2) @(posedge clk);
		#1;
		chk({rnd, rspv, hit, dm, ae}, {5'h1F, 4'h0});
		rst = 1'b0;
		@(posedge clk);
		#1;
		chk(rnd, 5'h1E);
		// indexed refill, even/odd pair in 32-bit mode with 4K pages
		i_atb_pipe_model.refill(1'b0, 5'h00, ent(27'h201, 3'h0, 1'b0,
			pg(20'h12345, 3'h3, 1'b1, 1'b1), pg(20'h0ABCD, 3'h5, 1'b0, 1'b1)));
		i_atb_pipe_model.refill(1'b0, 5'h1F, ent(27'h91A, 3'h0, 1'b1,
			pg(20'h00777, 3'h2, 1'b1, 1'b0), pg(20'h00888, 3'h2, 1'b1, 1'b1)));
		xq(0, 0, 64'h0040_2ABC, 32'h1234_5ABC, 6'h1F, 6'h00, 1);
		xq(0, 1, 64'h0040_3ABC, 32'h0ABC_DABC, 6'h2B, 6'h02, 1);
		xq(1, 0, 64'h0040_3ABC, 32'h0ABC_DABC, 6'h2B, 6'h00, 1);
		xq(0, 0, 64'h0040_3ABC, 32'h0ABC_DABC, 6'h2B, 6'h00, 1);
		key = 8'h06;
		xq(0, 0, 64'h0040_2ABC, 32'h0, 6'h00, 6'h08, 0);
		xq(1, 0, 64'h0040_2ABC, 32'h0, 6'h00, 6'h20, 0);
		xq(0, 0, 64'h0123_4010, 32'h0, 6'h15, 6'h04, 0);
		xq(1, 0, 64'h0123_4010, 32'h0, 6'h15, 6'h10, 0);
		xq(0, 1, 64'h0123_5010, 32'h0088_8010, 6'h17, 6'h00, 1);
		// random refill for every page size, 64-bit mode
		key = 8'h05;
		m64 = 1'b1;
		for (int s = 0; s < 7; s++)
		begin
			logic [63:0] a, mk;
			logic [19:0] pf;
			mk = (64'h1 << (12 + 2 * s)) - 64'h1;
			a = (64'(s + 1) << 36) | (64'h1 << (12 + 2 * s)) | (mk & 64'h0000_0000_00A5_A5A5);
			pf = 20'(s + 1) << 12;
			r = rnd;
			@(posedge clk);
			#1;
			chk(rnd, 5'(r - 5'h01));
			i_atb_pipe_model.refill(1'b1, 5'h00, ent(a[39:13], 3'(s), 1'b0,
				pg(20'hFF000, 3'h1, 1'b1, 1'b0), pg(pf, 3'h4, 1'b1, 1'b1)));
			xq(0, 1, a, {pf, 12'h000} | (a[31:0] & mk[31:0]), 6'h27, 6'h00, 1);
		end
		// direct windows, kernel only
		m64 = 1'b0;
		kern = 1'b1;
		xq(0, 0, 64'hFFFF_FFFF_8012_3456, 32'h0012_3456, 6'h1E, 6'h00, 1);
		chk({cache, wrt, pv, hit}, 6'h1E);
		xq(1, 1, 64'hFFFF_FFFF_A012_3456, 32'h0012_3456, 6'h16, 6'h00, 1);
		chk(cache, 3'h2);
		// 64-bit mode: a window needs the sign-extended upper half, else it is mapped
		m64 = 1'b1;
		xq(0, 0, 64'hFFFF_FFFF_8012_3456, 32'h0012_3456, 6'h1E, 6'h00, 1);
		xq(0, 0, 64'h0000_0000_8012_3456, 32'h0, 6'h00, 6'h08, 0);
		m64 = 1'b0;
		// user region limits
		kern = 1'b0;
		usr = 1'b1;
		xq(0, 0, 64'hFFFF_FFFF_8000_0000, 32'h0, 6'h00, 6'h01, 0);
		m64 = 1'b1;
		xq(1, 0, 64'h0000_0100_0000_0000, 32'h0, 6'h00, 6'h01, 0);
		xq(0, 0, 64'h0000_00FF_FFFF_F000, 32'h0, 6'h00, 6'h08, 0);
		// mid-run reset empties the store, so the first loop page now misses
		rst = 1'b1;
		@(posedge clk);
		#1;
		chk({rnd, rspv, hit}, {5'h1F, 2'h0});
		rst = 1'b0;
		xq(0, 1, 64'h0000_0010_0000_15A5, 32'h0, 6'h00, 6'h08, 0);
		report_and_stop();
	end
endmodule // tb
